// file: hw/ire_defines.vh
/*
  Constants for the interrupt redirection entry block: register indices,
  field positions, reset values and delivery codes.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef IRE_DEFINES_VH
`define IRE_DEFINES_VH

`define IRE_NUM_INPUTS      24
`define IRE_LOW_BASE_IDX    8'h10
`define IRE_HIGH_BASE_IDX   8'h11
`define IRE_HIGH_LAST_IDX   8'h3F
`define IRE_CTRL_IDX        8'h00
`define IRE_EOI_IDX         8'h41
`define IRE_HIGH_RESET      32'h00000000
`define IRE_LOW_RESET       32'h00010000
`define IRE_LOW_WMASK       32'h0001AFFF
`define IRE_HIGH_WMASK      32'hFFFF0000
`define IRE_VEC_LSB         0
`define IRE_VEC_MSB         7
`define IRE_DEL_LSB         8
`define IRE_DEL_MSB         10
`define IRE_TARGET_MODE_BIT        11
`define IRE_DS_BIT          12
`define IRE_POL_BIT         13
`define IRE_RACC_BIT        14
`define IRE_TRIG_BIT        15
`define IRE_MASK_BIT        16
`define IRE_TID_LSB         24
`define IRE_TID_MSB         31
`define IRE_XID_LSB         16
`define IRE_XID_MSB         23
`define IRE_DEL_FIXED       3'h0
`define IRE_DEL_LOWEST      3'h1
`define IRE_ADDR_BASE       12'hFEE

`endif

// file: hw/ire_input_detect.v
/*
  Per-input detector: synchronises a pin, applies polarity and reports an
  edge or a level request.
  Assumes the pin is asynchronous to clk_sys.
*/
`timescale 1ns/1ns
module ire_input_detect (
  input  wire clk_sys,
  input  wire rstn,
  input  wire clkEn,
  input  wire pinIn,
  input  wire activeLow,
  input  wire levelMode,
  output wire request
);
  reg syncA_q;
  reg syncB_q;
  reg prev_q;
  wire active;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q  <= 1'b0;
    end else if (clkEn) begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
      prev_q  <= active;
    end
  end

  assign active = syncB_q ^ activeLow;
  assign request = levelMode ? active : (active & ~prev_q);
endmodule // ire_input_detect

// file: hw/ire_redirection_entry.v
/*
  Interrupt redirection table: per input a low word (vector, delivery kind,
  target mode, polarity, trigger kind, mask) and a high word (target ids),
  an APB slave, and a message sender toward the local controllers.
  Assumes the message sink answers with msgAccept and sends EOIs by vector.
*/
`timescale 1ns/1ns
`include "ire_defines.vh"

// Function
// - Logical mode: controllers match bits 63:56
// - Delivery codes 000 fixed, 001 lowest
// - High word per input, 11h step two
// - Target id into address bits 19:12
// - Extended id into address bits 11:4
// - Bits 15:0 reserved; reset zero
// - High word addresses the message
// - Masked input neither delivers nor pends; pending clears a cycle after the mask is set, and the pick ignores the mask
// - Trigger bit: 0 edge, 1 level
// - Remote accepted set on accept of a level message, EOI clears
// - Physical mode uses bits 59:56
module ire_redirection_entry #(
  parameter NUM_INPUTS = `IRE_NUM_INPUTS
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        clkEn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [NUM_INPUTS-1:0] irqPin,
  output reg         msgValid,
  output reg  [31:0] msgAddr,
  output reg  [7:0]  msgVector,
  output reg  [2:0]  msgDeliveryKind,
  output reg         msgTargetMode,
  output reg         msgLevel,
  input  wire        msgAccept,
  input  wire        eoiValid,
  input  wire [7:0]  eoiVector
);
  reg  [31:0] lowWord_q  [0:NUM_INPUTS-1];
  reg  [31:0] highWord_q [0:NUM_INPUTS-1];
  reg  [NUM_INPUTS-1:0] pending_q;
  reg  [NUM_INPUTS-1:0] remoteAccepted_q;
  reg  [4:0]  sendIdx_q;
  reg         enable_q;
  wire [NUM_INPUTS-1:0] request;
  wire        wrEn;
  wire        rdEn;
  wire [7:0]  regIdx;
  wire        inTable;
  wire [7:0]  tblOff;
  wire [4:0]  tblEntry;
  wire        tblHigh;
  reg  [4:0]  pickIdx;
  reg         pickFound;
  reg  [31:0] pickSum;
  integer     k;
  integer     j;

  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g = g + 1) begin : gDetect
      ire_input_detect uDetect (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clkEn     (clkEn),
        .pinIn     (irqPin[g]),
        .activeLow (lowWord_q[g][`IRE_POL_BIT]),
        .levelMode (lowWord_q[g][`IRE_TRIG_BIT]),
        .request   (request[g])
      );
    end
  endgenerate

  // Registers answer with no wait state; word address is byte address over four.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign regIdx  = {2'b00, paddr[7:2]};
  assign wrEn    = psel & penable & pwrite & clkEn;
  assign rdEn    = psel & penable & ~pwrite;
  assign tblOff  = regIdx - `IRE_LOW_BASE_IDX;
  assign inTable = (regIdx >= `IRE_LOW_BASE_IDX) && (regIdx <= `IRE_HIGH_LAST_IDX);
  assign tblEntry = tblOff[5:1];
  assign tblHigh  = tblOff[0];

  always @* begin
    prdata = 32'h00000000;
    if (rdEn) begin
      if (inTable) begin
        if (tblHigh) begin
          prdata = highWord_q[tblEntry] & `IRE_HIGH_WMASK;
        end else begin
          prdata = lowWord_q[tblEntry];
          prdata[`IRE_RACC_BIT] = remoteAccepted_q[tblEntry];
          prdata[`IRE_DS_BIT]   = pending_q[tblEntry];
        end
      end else if (regIdx == `IRE_CTRL_IDX) begin
        prdata = {31'h00000000, enable_q};
      end
    end
  end

  // Round-robin pick of the next pending entry after the last one sent.
  always @* begin
    pickIdx   = 5'h00;
    pickFound = 1'b0;
    pickSum   = 32'h00000000;
    for (j = NUM_INPUTS - 1; j >= 0; j = j - 1) begin
      pickSum = (sendIdx_q + 1 + j) % NUM_INPUTS;
      if (pending_q[pickSum]) begin
        pickIdx   = pickSum[4:0];
        pickFound = 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      for (k = 0; k < NUM_INPUTS; k = k + 1) begin
        lowWord_q[k]  <= `IRE_LOW_RESET;
        highWord_q[k] <= `IRE_HIGH_RESET;
      end
      pending_q        <= {NUM_INPUTS{1'b0}};
      remoteAccepted_q <= {NUM_INPUTS{1'b0}};
      sendIdx_q        <= 5'h00;
      enable_q         <= 1'b0;
      msgValid         <= 1'b0;
      msgAddr          <= 32'h00000000;
      msgVector        <= 8'h00;
      msgDeliveryKind  <= 3'h0;
      msgTargetMode    <= 1'b0;
      msgLevel         <= 1'b0;
    end else if (clkEn) begin
      if (wrEn && inTable) begin
        if (tblHigh) begin
          highWord_q[tblEntry] <= pwdata & `IRE_HIGH_WMASK;
        end else begin
          lowWord_q[tblEntry] <= pwdata & `IRE_LOW_WMASK;
        end
      end
      if (wrEn && (regIdx == `IRE_CTRL_IDX)) begin
        enable_q <= pwdata[0];
      end
      for (k = 0; k < NUM_INPUTS; k = k + 1) begin
        if (lowWord_q[k][`IRE_MASK_BIT]) begin
          pending_q[k] <= 1'b0;
        end else if (request[k] && !(lowWord_q[k][`IRE_TRIG_BIT] && remoteAccepted_q[k])) begin
          pending_q[k] <= 1'b1;
        end
        if (eoiValid && (eoiVector == lowWord_q[k][`IRE_VEC_MSB:`IRE_VEC_LSB])) begin
          remoteAccepted_q[k] <= 1'b0;
        end
      end
      if (msgValid) begin
        if (msgAccept) begin
          msgValid <= 1'b0;
          pending_q[sendIdx_q] <= request[sendIdx_q] & msgLevel;
          if (msgLevel) begin
            remoteAccepted_q[sendIdx_q] <= 1'b1;
            pending_q[sendIdx_q] <= 1'b0;
          end
        end
      end else if (enable_q && pickFound) begin
        sendIdx_q <= pickIdx;
        msgValid  <= 1'b1;
        msgAddr <= {`IRE_ADDR_BASE,
                    lowWord_q[pickIdx][`IRE_TARGET_MODE_BIT] ?
                      highWord_q[pickIdx][`IRE_TID_MSB:`IRE_TID_LSB] :
                      {4'h0, highWord_q[pickIdx][27:24]},
                    highWord_q[pickIdx][`IRE_XID_MSB:`IRE_XID_LSB],
                    4'h0};
        msgVector       <= lowWord_q[pickIdx][`IRE_VEC_MSB:`IRE_VEC_LSB];
        msgDeliveryKind <= lowWord_q[pickIdx][`IRE_DEL_MSB:`IRE_DEL_LSB];
        msgTargetMode   <= lowWord_q[pickIdx][`IRE_TARGET_MODE_BIT];
        msgLevel        <= lowWord_q[pickIdx][`IRE_TRIG_BIT];
      end
    end
  end
endmodule // ire_redirection_entry

// file: verification/ire_msg_sink.sv
/* Message sink standing for the local controllers.
   Assumes the bench sets the accept wait and asks for EOIs. */
`timescale 1ns/1ns
module ire_msg_sink (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       msgValid,
  input  wire [7:0] msgVector,
  input  wire [3:0] waitCycles,
  input  wire       eoiReq,
  output reg        msgAccept,
  output reg        eoiValid,
  output reg  [7:0] eoiVector,
  output reg  [7:0] gotCount
);
  reg [3:0] waitQ;
  reg [7:0] heldVec;
  always @(posedge clk_sys) begin
    waitQ <= (msgValid && !msgAccept) ? waitQ + 4'h1 : 4'h0;
    msgAccept <= rstn && msgValid && !msgAccept && waitQ >= waitCycles;
    if (msgAccept) heldVec <= msgVector;
    eoiValid <= eoiReq;
    // Outside an EOI the vector lines show the inverse of the held vector.
    eoiVector <= eoiReq ? heldVec : ~heldVec;
    gotCount <= !rstn ? 8'h00 : gotCount + {7'h00, msgAccept};
  end
endmodule // ire_msg_sink

// file: verification/ire_redirection_entry_monitor.sv
/* Port checker for the redirection entry block.
   Assumes a bind to the block's top module. */
`timescale 1ns/1ns
module ire_redirection_entry_monitor (
  input wire        clk_sys,
  input wire        rstn,
  input wire        clkEn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        msgValid,
  input wire [31:0] msgAddr,
  input wire        msgTargetMode,
  input wire        msgAccept
);
  wire rdHigh = psel && penable && !pwrite && paddr[2] && paddr[7:2] > 6'h10;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_addr_base: assert property (msgValid |-> msgAddr[31:20] == 12'hFEE)
    else $error("bad address base");
  a_addr_low: assert property (msgValid |-> msgAddr[3:0] == 4'h0)
    else $error("bad address low bits");
  a_phys_id: assert property (msgValid && !msgTargetMode |-> msgAddr[19:16] == 4'h0)
    else $error("physical id too wide");
  a_msg_hold: assert property (msgValid && !msgAccept |=> msgValid && $stable(msgAddr))
    else $error("message changed early");
  a_accept_end: assert property (msgValid && msgAccept && clkEn |=> !msgValid)
    else $error("message kept after accept");
  a_fall_cause: assert property ($fell(msgValid) |-> $past(msgAccept))
    else $error("message lost");
  a_rsvd_zero: assert property (rdHigh |-> prdata[15:0] == 16'h0000)
    else $error("reserved bits set");
  a_idle_rdata: assert property (!(psel && penable) |-> prdata == 32'h00000000)
    else $error("read data outside access");
  cover property (msgValid && msgAccept);
  cover property (msgValid && !msgTargetMode);
  cover property (rdHigh);
endmodule // ire_redirection_entry_monitor

// file: verification/ire_redirection_entry_tb.sv
/* Bench for the redirection entry block with a message sink.
   Assumes the send enable sits at byte address 00h. */
`timescale 1ns/1ns
module ire_redirection_entry_tb;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg  [23:0] irqPin = 24'h0;
  reg  [3:0]  waitCycles = 4'h0;
  reg         eoiReq = 1'b0;
  reg  [71:0] rows [0:3];
  reg  [31:0] rd;
  integer     numErrors = 0;
  integer     checkCount = 0;
  integer     cycles = 0;
  integer     i;
  wire [31:0] prdata, msgAddr;
  wire [7:0]  msgVector, eoiVector, gotCount;
  wire [2:0]  msgDeliveryKind;
  wire        pready, pslverr, msgValid, msgTargetMode, msgLevel, msgAccept, eoiValid;
  ire_redirection_entry i_ire_redirection_entry (.clk_sys, .rstn, .clkEn(1'b1), .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irqPin, .msgValid, .msgAddr,
    .msgVector, .msgDeliveryKind, .msgTargetMode, .msgLevel, .msgAccept, .eoiValid, .eoiVector);
  ire_msg_sink i_ire_msg_sink (.clk_sys, .rstn, .msgValid, .msgVector, .waitCycles, .eoiReq,
    .msgAccept, .eoiValid, .eoiVector, .gotCount);
  initial forever #25 clk_sys = ~clk_sys;
  task giveVerdict;
    begin
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checkCount = checkCount + 1;
      if (got !== exp) begin
        numErrors = numErrors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task waitMsg(input [31:0] a, input [31:0] f);
    begin
      do @(negedge clk_sys); while (msgValid !== 1'b1);
      chk(msgAddr, a);
      chk({msgVector, msgDeliveryKind, msgTargetMode, msgLevel}, f);
      @(posedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      numErrors = numErrors + 1;
      giveVerdict;
    end
  end
  initial begin
    rows[0] = {8'h44, 32'hA53CFFFF, 32'hA53C0000};
    rows[1] = {8'h6C, 32'h12345678, 32'h12340000};
    rows[2] = {8'hFC, 32'hFFFFFFFF, 32'hFFFF0000};
    rows[3] = {8'h04, 32'hFFFFFFFF, 32'h00000000};
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(8'h44, 1'b0, 32'h0);
    chk(rd, 32'h00000000);
    apb(8'h40, 1'b0, 32'h0);
    chk(rd, 32'h00010000);
    for (i = 0; i < 4; i = i + 1) begin
      apb(rows[i][71:64], 1'b1, rows[i][63:32]);
      apb(rows[i][71:64], 1'b0, 32'h0);
      chk(rd, rows[i][31:0]);
    end
    irqPin[23] <= 1'b1;
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h44, 1'b1, 32'hA53C0000);
    apb(8'h40, 1'b1, 32'h00000810);
    irqPin[0] <= 1'b1;
    waitMsg(32'hFEEA53C0, 32'h00000202);
    waitCycles <= 4'h5;
    apb(8'h6C, 1'b1, 32'hA7000000);
    apb(8'h68, 1'b1, 32'h000081FE);
    irqPin[5] <= 1'b1;
    waitMsg(32'hFEE07000, 32'h00001FC5);
    while (gotCount !== 8'h02) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    apb(8'h68, 1'b0, 32'h0);
    chk(rd, 32'h0000C1FE);
    chk(gotCount, 32'h2);
    eoiReq <= 1'b1;
    @(posedge clk_sys);
    eoiReq <= 1'b0;
    while (gotCount !== 8'h03) @(posedge clk_sys);
    irqPin <= 24'h0;
    repeat (20) @(posedge clk_sys);
    chk(gotCount, 32'h3);
    giveVerdict;
  end
endmodule // ire_redirection_entry_tb
bind ire_redirection_entry ire_redirection_entry_monitor i_ire_redirection_entry_monitor (
  .clk_sys, .rstn, .clkEn, .psel, .penable, .pwrite, .paddr, .prdata, .msgValid, .msgAddr,
  .msgTargetMode, .msgAccept);
